// *** port_power_map.vh ***
`ifndef PORT_POWER_MAP_VH
`define PORT_POWER_MAP_VH

// ****************************************
// clock and timing
// ****************************************
`define CLK_HZ 20000000
`define MASK_TIME_US 1000
`define BLANK_TIME_US 5000
`define MASK_CYCLES 24'h004E20
`define BLANK_CYCLES 24'h0186A0

// ****************************************
// register byte offsets
// ****************************************
`define CTRL_OFS 4'h0
`define LIMIT_OFS 4'h4
`define STATUS_OFS 4'h8
`define REARM_OFS 4'hC

// ****************************************
// control register fields
// ****************************************
`define CTRL_IGNORE_PINS 0
`define CTRL_SW_MODE_A 1
`define CTRL_SW_MODE_B 2
`define CTRL_SW_EMUL 3
`define CTRL_SW_POWER 4
`define CTRL_SW_HOLD 5
`define CTRL_SW_DETECT 6
`define CTRL_DS_DEDICATED 7
`define CTRL_DS_EMUL 8
`define CTRL_DS_DETECT 9
`define CTRL_ALERT_MASK 10
`define CTRL_LINK_LOW 11
`define CTRL_LINK_THERM 12
`define CTRL_RATION_LO 13
`define CTRL_RATION_HI 14
`define CTRL_WIDTH 15
`define CTRL_RESET 15'h0000
`define LIMIT_RESET 3'h7

// ****************************************
// power states
// ****************************************
`define ST_SLEEP 2'h0
`define ST_DETECT 2'h1
`define ST_ACTIVE 2'h2
`define ST_ERROR 2'h3

// ****************************************
// pin sample vector
// ****************************************
`define PIN_W 26

`endif

// *** usb_port_power_ctrl_logic.v ***
// Local design decisions: the register addresses and the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
`include "port_power_map.vh"

module usb_port_power_ctrl_logic #(
    parameter [23:0] MASK_CYCLES = `MASK_CYCLES,
    parameter [23:0] BLANK_CYCLES = `BLANK_CYCLES
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // avalon-mm slave
    input wire [3:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    output reg [31:0] readdata,
    output wire waitrequest,
    // control pins
    input wire power_enable_ctl,
    input wire polaritySelect,
    input wire mode_select_a,
    input wire mode_select_b,
    input wire emulation_enable,
    input wire faultHoldPin,
    input wire detect_enable,
    input wire [3:0] comm_and_limit_select,
    // analog monitors and events
    input wire source_overvoltage_level,
    input wire sourceUndervoltage,
    input wire coreSupplyOk,
    input wire thermalShutdown,
    input wire overCurrent,
    input wire backDrive,
    input wire attachEvent,
    input wire removalEvent,
    input wire chargingActive,
    input wire low_draw_flag,
    input wire thermal_reg_flag,
    input wire rationReached,
    input wire busDischarging,
    input wire emulatingNonCdp,
    input wire dedicatedCharger,
    // switches
    output reg portSwitchOn,
    output reg dataSwitchOn,
    // open-drain indications, driven low while enable is high
    output wire alertOut,
    output reg alertOe,
    output wire attachOut,
    output reg attach_flag_n_oe,
    output wire chargingOut,
    output reg charging_flag_n_oe,
    // status to the rest of the chip
    output reg [2:0] current_limit,
    output reg [11:0] limitMa,
    output reg smbusAddrSel,
    output reg faultHoldSel,
    output reg [1:0] powerState
);

    // ****************************************
    // functions
    // ****************************************
    function [11:0] decodeMa;
        input [2:0] code;
        begin
            case (code)
                3'h0: decodeMa = 12'h23A;
                3'h1: decodeMa = 12'h3E8;
                3'h2: decodeMa = 12'h46A;
                3'h3: decodeMa = 12'h546;
                3'h4: decodeMa = 12'h690;
                3'h5: decodeMa = 12'h802;
                3'h6: decodeMa = 12'h8E8;
                default: decodeMa = 12'hB22;
            endcase
        end
    endfunction

    // pin with its software bit, per the comm mode
    function pickCtl;
        input smb;
        input ign;
        input pin;
        input sw;
        begin
            if (!smb) begin
                pickCtl = pin;
            end else if (ign) begin
                pickCtl = sw;
            end else begin
                pickCtl = pin | sw;
            end
        end
    endfunction

    // ****************************************
    // input synchronisers
    // ****************************************
    wire [`PIN_W-1:0] pinRaw = {power_enable_ctl, polaritySelect,
        mode_select_a, mode_select_b, emulation_enable, faultHoldPin,
        detect_enable, comm_and_limit_select, source_overvoltage_level,
        sourceUndervoltage, coreSupplyOk, thermalShutdown, overCurrent,
        backDrive, attachEvent, removalEvent, chargingActive, low_draw_flag,
        thermal_reg_flag, rationReached, busDischarging, emulatingNonCdp,
        dedicatedCharger};
    reg [`PIN_W-1:0] syncA_reg;
    reg [`PIN_W-1:0] syncB_reg;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            syncA_reg <= {`PIN_W{1'b0}};
            syncB_reg <= {`PIN_W{1'b0}};
        end else begin
            syncA_reg <= pinRaw;
            syncB_reg <= syncA_reg;
        end
    end

    wire pwrPin = syncB_reg[25];
    wire polPin = syncB_reg[24];
    wire modeAPin = syncB_reg[23];
    wire modeBPin = syncB_reg[22];
    wire emulPin = syncB_reg[21];
    wire holdPin = syncB_reg[20];
    wire detPin = syncB_reg[19];
    wire [3:0] selCode = syncB_reg[18:15];
    wire ovLevel = syncB_reg[14];
    wire uvlo = syncB_reg[13];
    wire coreOk = syncB_reg[12];
    wire tsd = syncB_reg[11];
    wire ocLevel = syncB_reg[10];
    wire bdLevel = syncB_reg[9];
    wire attachEv = syncB_reg[8];
    wire removalEv = syncB_reg[7];
    wire chargeAct = syncB_reg[6];
    wire lowDraw = syncB_reg[5];
    wire thermReg = syncB_reg[4];
    wire rationHit = syncB_reg[3];
    wire discharging = syncB_reg[2];
    wire emulNonCdp = syncB_reg[1];
    wire dedicated = syncB_reg[0];

    // ****************************************
    // power-up capture and blanking
    // ****************************************
    // capture waits for synchronised pins, two edges after release
    reg [1:0] capCnt_reg;
    reg captured_reg;
    reg polarity_reg;
    reg smbusMode_reg;
    reg [2:0] hwLimit_reg;
    reg [23:0] blankCnt_reg;
    wire blanking = blankCnt_reg != BLANK_CYCLES;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            capCnt_reg <= 2'h0;
            captured_reg <= 1'b0;
            polarity_reg <= 1'b1;
            smbusMode_reg <= 1'b0;
            hwLimit_reg <= 3'h0;
            blankCnt_reg <= 24'h000000;
        end else begin
            if (blanking) begin
                blankCnt_reg <= blankCnt_reg + 24'h000001;
            end
            if (capCnt_reg != 2'h2) begin
                capCnt_reg <= capCnt_reg + 2'h1;
            end else if (!captured_reg) begin
                captured_reg <= 1'b1;
                polarity_reg <= polPin;
                hwLimit_reg <= selCode[2:0];
                smbusMode_reg <= selCode[3];
            end
        end
    end

    // ****************************************
    // register file
    // ****************************************
    reg [`CTRL_WIDTH-1:0] ctrl_reg;
    reg [2:0] swLimit_reg;
    reg respond_reg;
    wire take = (read | write) & respond_reg;
    wire rearmWrite = take & write & (address == `REARM_OFS) & writedata[0];
    wire [31:0] statusWord;

    // one wait cycle per access; readdata set up during the wait
    assign waitrequest = (read | write) & ~respond_reg;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            respond_reg <= 1'b0;
            readdata <= 32'h00000000;
            ctrl_reg <= `CTRL_RESET;
            swLimit_reg <= `LIMIT_RESET;
        end else begin
            respond_reg <= (read | write) & ~respond_reg;
            if (read & ~respond_reg) begin
                case (address)
                    `CTRL_OFS: readdata <= {17'h00000, ctrl_reg};
                    `LIMIT_OFS: readdata <= {29'h00000000, swLimit_reg};
                    `STATUS_OFS: readdata <= statusWord;
                    default: readdata <= 32'h00000000;
                endcase
            end
            if (take & write & (address == `CTRL_OFS)) begin
                ctrl_reg <= writedata[`CTRL_WIDTH-1:0];
            end
            if (take & write & (address == `LIMIT_OFS)) begin
                swLimit_reg <= writedata[2:0];
            end
        end
    end

    wire ignorePins = ctrl_reg[`CTRL_IGNORE_PINS];

    // ****************************************
    // effective controls
    // ****************************************
    // apply enable polarity
    wire pwrPinEff = polarity_reg ? pwrPin : ~pwrPin;
    wire pwrEn = captured_reg & pickCtl(smbusMode_reg, ignorePins,
        pwrPinEff, ctrl_reg[`CTRL_SW_POWER]);
    wire modeA = pickCtl(smbusMode_reg, ignorePins, modeAPin,
        ctrl_reg[`CTRL_SW_MODE_A]);
    wire modeB = pickCtl(smbusMode_reg, ignorePins, modeBPin,
        ctrl_reg[`CTRL_SW_MODE_B]);
    wire emul = pickCtl(smbusMode_reg, ignorePins, emulPin,
        ctrl_reg[`CTRL_SW_EMUL]);
    wire modesZero = ~(modeA | modeB | emul);
    wire detEn = smbusMode_reg ? ctrl_reg[`CTRL_SW_DETECT] : detPin;
    wire detectOn = detEn & ~(modesZero & pwrEn);

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            faultHoldSel <= 1'b0;
            smbusAddrSel <= 1'b0;
        end else begin
            faultHoldSel <= smbusMode_reg ? ctrl_reg[`CTRL_SW_HOLD] : holdPin;
            smbusAddrSel <= smbusMode_reg & polarity_reg;
        end
    end

    // ****************************************
    // fault filtering
    // ****************************************
    reg [23:0] ovCnt_reg;
    reg [23:0] faultCnt_reg;
    wire ovPersist = ovCnt_reg == MASK_CYCLES;
    wire faultPersist = faultCnt_reg == MASK_CYCLES;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ovCnt_reg <= 24'h000000;
            faultCnt_reg <= 24'h000000;
        end else begin
            if (!ovLevel) begin
                ovCnt_reg <= 24'h000000;
            end else if (!ovPersist) begin
                ovCnt_reg <= ovCnt_reg + 24'h000001;
            end
            if (!(ocLevel | bdLevel)) begin
                faultCnt_reg <= 24'h000000;
            end else if (!faultPersist) begin
                faultCnt_reg <= faultCnt_reg + 24'h000001;
            end
        end
    end

    wire errorCause = ovPersist | faultPersist | tsd;

    // ****************************************
    // power state machine
    // ****************************************
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg attached_reg;
    reg rearm_reg;
    reg pwrEnDly_reg;
    wire canActive = ~uvlo & pwrEn & ~modesZero & (~detEn | attached_reg);
    wire [1:0] homeState = canActive ? `ST_ACTIVE :
        (detectOn ? `ST_DETECT : `ST_SLEEP);
    // latched faults need a rearm or a removal event; auto-recovery only needs causes gone
    wire errorExit = ~errorCause & (~faultHoldSel | rearm_reg | removalEv);

    always @* begin
        state_next = state_reg;
        case (state_reg)
            `ST_ACTIVE: begin
                if (errorCause) begin
                    state_next = `ST_ERROR;
                end else begin
                    state_next = homeState;
                end
            end
            `ST_DETECT: begin
                if (tsd | faultPersist) begin
                    state_next = `ST_ERROR;
                end else begin
                    state_next = homeState;
                end
            end
            `ST_SLEEP: begin
                if (faultPersist) begin
                    state_next = `ST_ERROR;
                end else begin
                    state_next = homeState;
                end
            end
            `ST_ERROR: begin
                if (errorExit) begin
                    state_next = homeState;
                end
            end
            default: state_next = `ST_SLEEP;
        endcase
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= `ST_SLEEP;
            attached_reg <= 1'b0;
            rearm_reg <= 1'b0;
            pwrEnDly_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            pwrEnDly_reg <= pwrEn;
            // set wins over clear when both land together
            if (rearmWrite | (pwrEnDly_reg & ~pwrEn)) begin
                rearm_reg <= 1'b1;
            end else if (state_reg != `ST_ERROR) begin
                rearm_reg <= 1'b0;
            end
            // hold attach until removal, detection off, or a move to sleep
            if (attachEv & detectOn) begin
                attached_reg <= 1'b1;
            end else if (removalEv | ~detectOn |
                (state_next == `ST_SLEEP)) begin
                attached_reg <= 1'b0;
            end
        end
    end

    // ****************************************
    // switches and current limit
    // ****************************************
    wire inActive = state_reg == `ST_ACTIVE;
    wire [2:0] clampLimit = (swLimit_reg > hwLimit_reg) ? hwLimit_reg :
        swLimit_reg;
    wire [2:0] effLimit = smbusMode_reg ? clampLimit : hwLimit_reg;
    wire dsBlocked = (emulNonCdp & ~ctrl_reg[`CTRL_DS_EMUL]) |
        (dedicated & ~ctrl_reg[`CTRL_DS_DEDICATED]);

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            portSwitchOn <= 1'b0;
            dataSwitchOn <= 1'b0;
            current_limit <= 3'h0;
            limitMa <= 12'h000;
            powerState <= `ST_SLEEP;
        end else begin
            portSwitchOn <= inActive & pwrEn & ~discharging & ~errorCause;
            dataSwitchOn <= coreOk & ((inActive & ~dsBlocked) |
                ((state_reg == `ST_DETECT) & ctrl_reg[`CTRL_DS_DETECT]));
            current_limit <= effLimit;
            limitMa <= decodeMa(effLimit);
            powerState <= state_reg;
        end
    end

    // ****************************************
    // open-drain indications
    // ****************************************
    // alert sources
    wire alertCond = ((state_reg == `ST_ERROR) &
        ~ctrl_reg[`CTRL_ALERT_MASK]) |
        (lowDraw & ctrl_reg[`CTRL_LINK_LOW]) |
        (thermReg & ctrl_reg[`CTRL_LINK_THERM]) |
        (rationHit & (ctrl_reg[`CTRL_RATION_HI:`CTRL_RATION_LO] != 2'h0));
    wire attachCond = attached_reg | (inActive & ~detEn);

    assign alertOut = 1'b0;
    assign attachOut = 1'b0;
    assign chargingOut = 1'b0;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            alertOe <= 1'b0;
            attach_flag_n_oe <= 1'b0;
            charging_flag_n_oe <= 1'b0;
        end else begin
            alertOe <= ~blanking & alertCond;
            attach_flag_n_oe <= ~blanking & attachCond;
            charging_flag_n_oe <= ~blanking & chargeAct;
        end
    end

    assign statusWord = {4'h0, decodeMa(effLimit), 2'h0, blanking,
        alertCond, rearm_reg, effLimit, hwLimit_reg, smbusMode_reg,
        polarity_reg, attached_reg, state_reg};

endmodule // usb_port_power_ctrl_logic

`default_nettype wire

// *** usb_port_power_ctrl_logic_props.sv ***
`timescale 1ns/100ps
`default_nettype none
module usb_port_power_ctrl_logic_props #(
    parameter [23:0] MASK_CYCLES = 24'h000008,
    parameter [23:0] BLANK_CYCLES = 24'h000004
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // watched inputs
    input wire logic source_overvoltage_level,
    input wire logic coreSupplyOk,
    input wire logic thermalShutdown,
    input wire logic chargingActive,
    // watched outputs
    input wire logic portSwitchOn,
    input wire logic dataSwitchOn,
    input wire logic alertOe,
    input wire logic attach_flag_n_oe,
    input wire logic charging_flag_n_oe,
    input wire logic [2:0] current_limit,
    input wire logic [11:0] limitMa,
    input wire logic [1:0] powerState
);
    // ****
    // counters
    // ****
    localparam logic [95:0] MA_TAB = {12'hB22, 12'h8E8, 12'h802, 12'h690,
        12'h546, 12'h46A, 12'h3E8, 12'h23A};
    logic [23:0] upCnt;
    logic [23:0] ovCnt;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            upCnt <= 24'h0;
            ovCnt <= 24'h0;
        end else begin
            upCnt <= upCnt + {23'h0, upCnt != 24'hFFFFFF};
            ovCnt <= source_overvoltage_level ? ovCnt + 24'h1 : 24'h0;
        end
    end
    default clocking dc @(posedge clk); endclocking
    default disable iff (rst);
    // ****
    // properties
    // ****
    chk_blank_quiet: assert property (
        upCnt < BLANK_CYCLES |-> !(alertOe | attach_flag_n_oe |
        charging_flag_n_oe)) else $error("indication during blanking");
    chk_switch_active: assert property (
        portSwitchOn |-> powerState == 2'h2 || $past(powerState) == 2'h2)
        else $error("port switch closed outside active");
    chk_data_active: assert property (
        dataSwitchOn |-> powerState == 2'h2 || $past(powerState) == 2'h2)
        else $error("data switch closed outside active");
    chk_core_open: assert property (
        !coreSupplyOk [*4] |-> !dataSwitchOn)
        else $error("data switch closed without core supply");
    chk_ov_error: assert property (
        ovCnt == MASK_CYCLES + 24'h6 && $past(powerState, 8) == 2'h2
        |-> powerState == 2'h3 && !portSwitchOn)
        else $error("overvoltage did not trip");
    chk_thermal_fast: assert property (
        powerState == 2'h2 && thermalShutdown ##1 thermalShutdown [*3]
        |=> powerState == 2'h3) else $error("thermal error late");
    chk_attach_sleep: assert property (
        powerState == 2'h0 [*3] |-> !attach_flag_n_oe)
        else $error("attach flag held in sleep");
    chk_charge_off: assert property (
        !chargingActive [*4] |-> !charging_flag_n_oe)
        else $error("charging flag without charging");
    chk_charge_on: assert property (
        (upCnt > BLANK_CYCLES + 24'h4 && chargingActive) [*4]
        |-> charging_flag_n_oe) else $error("charging flag missing");
    chk_limit_table: assert property (
        (upCnt > 24'hA && $stable(current_limit)) [*2]
        |-> limitMa == MA_TAB[current_limit * 12 +: 12])
        else $error("limit milliamps wrong");
    cover property (powerState == 2'h3);
    cover property (powerState == 2'h1 ##1 powerState == 2'h2);
    cover property (attach_flag_n_oe ##1 !attach_flag_n_oe);
endmodule // usb_port_power_ctrl_logic_props
`default_nettype wire

// *** usb_device_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module usb_device_model #(
    parameter int LAG = 2
) (
    // bench side
    input wire logic clk,
    input wire logic plugIn,
    input wire logic chargeWant,
    // block side
    input wire logic [2:0] sinkOe,
    output wire logic attachEvent,
    output wire logic removalEvent,
    output wire logic chargingActive,
    output wire logic [2:0] lineN
);
    // ****
    // plug history
    // ****
    logic [7:0] plugHist = 8'h00;
    always @(posedge clk) begin
        plugHist <= {plugHist[6:0], plugIn};
    end
    // slow device: edges seen LAG+1 cycles late, held four cycles
    assign attachEvent = plugHist[LAG] & ~plugHist[LAG + 4];
    assign removalEvent = ~plugHist[LAG] & plugHist[LAG + 4];
    assign chargingActive = plugHist[LAG] & chargeWant;
    // pull-ups hold each line high unless the block sinks it
    assign lineN = ~sinkOe;
endmodule // usb_device_model
`default_nettype wire

// *** usb_port_power_ctrl_logic_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module usb_port_power_ctrl_logic_bench;
    // ****
    // signals
    // ****
    logic clk = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0;
    logic [3:0] address = 4'h0, comm_and_limit_select = 4'hD;
    logic [31:0] writedata = 32'h0, rdat, r;
    logic power_enable_ctl = 1'b0, polaritySelect = 1'b1, act;
    logic mode_select_a = 1'b0, mode_select_b = 1'b0, faultHoldPin = 1'b0;
    logic emulation_enable = 1'b0, detect_enable = 1'b0;
    logic source_overvoltage_level = 1'b0, sourceUndervoltage = 1'b0;
    logic coreSupplyOk = 1'b1, thermalShutdown = 1'b0, low_draw_flag = 1'b0;
    logic thermal_reg_flag = 1'b0, rationReached = 1'b0;
    logic emulatingNonCdp = 1'b0, dedicatedCharger = 1'b0;
    logic busDischarging = 1'b0;
    logic plugIn = 1'b0, chargeWant = 1'b0;
    wire logic attachEvent, removalEvent, chargingActive, waitrequest;
    wire logic portSwitchOn, dataSwitchOn, smbusAddrSel, faultHoldSel;
    wire logic alertOe, attach_flag_n_oe, charging_flag_n_oe;
    wire logic [31:0] readdata;
    wire logic [2:0] current_limit, lineN;
    wire logic [1:0] powerState;
    int n_fail = 0;
    int checked = 0;
    always #25 clk = ~clk;
    usb_port_power_ctrl_logic #(
        .MASK_CYCLES(24'h000008), .BLANK_CYCLES(24'h000004)
    ) usb_port_power_ctrl_logic_i (
        .clk(clk), .rst(rst), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .power_enable_ctl(power_enable_ctl),
        .polaritySelect(polaritySelect), .mode_select_a(mode_select_a),
        .mode_select_b(mode_select_b), .emulation_enable(emulation_enable),
        .faultHoldPin(faultHoldPin), .detect_enable(detect_enable),
        .comm_and_limit_select(comm_and_limit_select),
        .source_overvoltage_level(source_overvoltage_level),
        .sourceUndervoltage(sourceUndervoltage),
        .coreSupplyOk(coreSupplyOk), .thermalShutdown(thermalShutdown),
        .overCurrent(1'b0), .backDrive(1'b0), .attachEvent(attachEvent),
        .removalEvent(removalEvent), .chargingActive(chargingActive),
        .low_draw_flag(low_draw_flag), .thermal_reg_flag(thermal_reg_flag),
        .rationReached(rationReached), .busDischarging(busDischarging),
        .emulatingNonCdp(emulatingNonCdp),
        .dedicatedCharger(dedicatedCharger), .portSwitchOn(portSwitchOn),
        .dataSwitchOn(dataSwitchOn), .alertOut(), .alertOe(alertOe),
        .attachOut(), .attach_flag_n_oe(attach_flag_n_oe),
        .chargingOut(), .charging_flag_n_oe(charging_flag_n_oe),
        .current_limit(current_limit), .limitMa(),
        .smbusAddrSel(smbusAddrSel), .faultHoldSel(faultHoldSel),
        .powerState(powerState)
    );
    usb_device_model #(.LAG(2)) usb_device_model_i (
        .clk(clk), .plugIn(plugIn), .chargeWant(chargeWant),
        .sinkOe({charging_flag_n_oe, attach_flag_n_oe, alertOe}),
        .attachEvent(attachEvent), .removalEvent(removalEvent),
        .chargingActive(chargingActive), .lineN(lineN)
    );
    // ****
    // tasks
    // ****
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] a,
        input logic [31:0] d);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= d;
        do @(posedge clk); while (waitrequest !== 1'b0);
        rdat = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic settle();
        repeat (10) @(posedge clk);
    endtask
    // recovery time is not fixed, so poll with a bound
    task automatic waitActive();
        for (int n = 0; n < 3000 && powerState !== 2'h2; n++) @(posedge clk);
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        n_fail++;
        end_of_test();
    end
    // ****
    // scenarios
    // ****
    initial begin
        r = $urandom(35318);
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (8) @(posedge clk);
        bus(1'b0, 4'h0, 32'h0);
        chk(rdat, 32'h0);
        bus(1'b0, 4'h2, 32'h0);
        chk(rdat, 32'h0);
        bus(1'b0, 4'h4, 32'h0);
        chk(rdat, 32'h7);
        chk(current_limit, 3'h5);
        for (int i = 0; i < 6; i++) begin
            r = $urandom;
            bus(1'b1, 4'h4, {29'h0, r[2:0]});
            settle();
            chk(current_limit, r[2:0] > 3'h5 ? 3'h5 : r[2:0]);
            bus(1'b0, 4'h4, 32'h0);
            chk(rdat, {29'h0, r[2:0]});
        end
        for (int i = 0; i < 16; i++) begin
            r = $urandom;
            bus(1'b1, 4'h0, {26'h0, r[3:2], 2'h0, r[1:0]});
            power_enable_ctl <= r[4];
            mode_select_a <= r[5];
            mode_select_b <= r[6] & r[7];
            emulation_enable <= r[8] & r[9];
            detect_enable <= r[10];
            polaritySelect <= r[11];
            faultHoldPin <= r[12];
            act = (r[2] | ~r[0] & r[4]) &
                (r[1] | ~r[0] & (r[5] | r[6] & r[7] | r[8] & r[9]));
            settle();
            chk(powerState == 2'h2, act);
            chk(portSwitchOn, act);
            chk(dataSwitchOn, act);
            chk(lineN[1], !act);
            chk(faultHoldSel, r[3]);
            chk(smbusAddrSel, 1'b1);
        end
        bus(1'b1, 4'h0, 32'h53);
        settle();
        chk(powerState, 2'h1);
        chk(portSwitchOn, 1'b0);
        plugIn <= 1'b1;
        chargeWant <= 1'b1;
        settle();
        chk(powerState, 2'h2);
        chk(lineN[2:1], 2'h0);
        chargeWant <= 1'b0;
        settle();
        chk(lineN[2], 1'b1);
        plugIn <= 1'b0;
        settle();
        chk({powerState, lineN[1]}, 3'h3);
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, 4'h0, 32'h13 | (i == 1) << 7 | (i == 3) << 8);
            dedicatedCharger <= i < 2;
            emulatingNonCdp <= i inside {2, 3};
            coreSupplyOk <= i != 4;
            busDischarging <= i == 4;
            settle();
            chk(dataSwitchOn, i == 1 || i == 3);
            chk(portSwitchOn, i != 4);
        end
        {busDischarging, dedicatedCharger, emulatingNonCdp,
            coreSupplyOk} <= 4'h1;
        for (int k = 0; k < 3; k++) begin
            bus(1'b1, 4'h0, 32'h13);
            {rationReached, thermal_reg_flag, low_draw_flag} <= 3'h1 << k;
            settle();
            chk(lineN[0], 1'b1);
            bus(1'b1, 4'h0, 32'h13 | 32'h800 << k);
            settle();
            chk(lineN[0], 1'b0);
            {rationReached, thermal_reg_flag, low_draw_flag} <= 3'h0;
            settle();
            chk(lineN[0], 1'b1);
        end
        for (int k = 0; k < 3; k++) begin
            bus(1'b1, 4'h0, k == 1 ? 32'h413 : 32'h13 | (k == 0) << 5);
            source_overvoltage_level <= 1'b1;
            thermalShutdown <= k == 2;
            repeat (k == 2 ? 5 : 4) @(posedge clk);
            chk({powerState, lineN[0]}, k == 2 ? 3'h6 : 3'h5);
            repeat (16) @(posedge clk);
            chk({powerState, portSwitchOn, lineN[0]},
                {2'h3, 1'b0, k == 1});
            {source_overvoltage_level, thermalShutdown} <= 2'h0;
            if (k == 0) begin
                settle();
                chk(powerState, 2'h3);
                bus(1'b1, 4'hC, 32'h1);
            end
            waitActive();
            chk({powerState, lineN[0]}, 3'h5);
        end
        rst <= 1'b1;
        polaritySelect <= 1'b0;
        comm_and_limit_select <= 4'h5;
        mode_select_a <= 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            {power_enable_ctl, detect_enable, faultHoldPin} <= i[2:0];
            settle();
            chk(powerState == 2'h2, i < 2);
            chk(faultHoldSel, i[0]);
            chk({smbusAddrSel, current_limit}, 4'h5);
        end
        end_of_test();
    end
endmodule // usb_port_power_ctrl_logic_bench
bind usb_port_power_ctrl_logic usb_port_power_ctrl_logic_props #(
    .MASK_CYCLES(MASK_CYCLES), .BLANK_CYCLES(BLANK_CYCLES)
) props_i (
    .clk(clk), .rst(rst), .source_overvoltage_level(source_overvoltage_level),
    .coreSupplyOk(coreSupplyOk), .thermalShutdown(thermalShutdown),
    .chargingActive(chargingActive), .portSwitchOn(portSwitchOn),
    .dataSwitchOn(dataSwitchOn), .alertOe(alertOe),
    .attach_flag_n_oe(attach_flag_n_oe),
    .charging_flag_n_oe(charging_flag_n_oe), .current_limit(current_limit),
    .limitMa(limitMa), .powerState(powerState)
);
`default_nettype wire
